// ===== hdl/sci_pkg.sv
package sci_pkg;
    // register indices: addr[4] picks channel b, addr[3:0] the index
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IE = 4'h1;
    localparam logic [3:0] REG_VEC = 4'h2;
    localparam logic [3:0] REG_RXSET = 4'h3;
    localparam logic [3:0] REG_IPEND = 4'h3;
    localparam logic [3:0] REG_MODE = 4'h4;
    localparam logic [3:0] REG_TXCTL = 4'h5;
    localparam logic [3:0] REG_MIC = 4'h9;
    localparam logic [3:0] REG_BRG_LO = 4'hc;
    localparam logic [3:0] REG_BRG_HI = 4'hd;
    localparam logic [3:0] REG_BRG_EN = 4'he;
    localparam int CHB_BIT = 4;
    // field positions
    localparam int EOI_BIT = 5;
    localparam int RX_EN_BIT = 0;
    localparam int TX_EN_BIT = 3;
    localparam int RTS_BIT = 1;
    localparam int DTR_BIT = 7;
    localparam int BRG_EN_BIT = 0;
    localparam int MIC_VIS = 0;
    localparam int MIC_NV = 1;
    localparam int MIC_DLC = 2;
    localparam int MIC_MIE = 3;
    localparam int MIC_STHI = 4;
    localparam int MIC_CMD_LO = 6;
    localparam int MIC_MODE_W = 5;
    localparam int SRC_EXT = 0;
    localparam int SRC_TX = 1;
    localparam int SRC_RX = 2;
    // reset command codes in bits 7:6
    localparam logic [1:0] CMD_NONE = 2'h0;
    localparam logic [1:0] CMD_RST_B = 2'h1;
    localparam logic [1:0] CMD_RST_A = 2'h2;
    localparam logic [1:0] CMD_RST_HW = 2'h3;
    // reset values
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [4:0] MIC_RST = 5'h00;
    // vector status codes
    localparam logic [2:0] VC_B_TX = 3'h0;
    localparam logic [2:0] VC_B_EXT = 3'h1;
    localparam logic [2:0] VC_B_RX = 3'h2;
    localparam logic [2:0] VC_NONE = 3'h3;
    localparam logic [2:0] VC_A_TX = 3'h4;
    localparam logic [2:0] VC_A_EXT = 3'h5;
    localparam logic [2:0] VC_A_RX = 3'h6;
    typedef enum logic {IA_IDLE, IA_DRIVE} sci_iack_t;
endpackage

// ===== hdl/sci_ch_if.sv
interface sci_ch_if;
    logic wr;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic chan_rst;
    logic eoi;
    logic [2:0] ev;
    logic [2:0] ack;
    logic txd_src;
    logic [2:0] ip;
    logic [2:0] interrupt_under_service_flag;
    logic [7:0] ie;
    logic [7:0] rxset;
    logic [7:0] mode;
    logic [7:0] txctl;
    logic [7:0] brg_lo;
    logic [7:0] brg_hi;
    logic brg_en;
    logic txd;
    logic rts_n;
    logic dtr_n;
    modport ctl (output wr, idx, wdata, chan_rst, eoi, ev, ack, txd_src,
        input ip, interrupt_under_service_flag, ie, rxset, mode, txctl, brg_lo, brg_hi, brg_en, txd, rts_n, dtr_n);
    modport chan (input wr, idx, wdata, chan_rst, eoi, ev, ack, txd_src,
        output ip, interrupt_under_service_flag, ie, rxset, mode, txctl, brg_lo, brg_hi, brg_en, txd, rts_n, dtr_n);
endinterface

// ===== hdl/sci_chan.sv
module sci_chan import sci_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control side
    sci_ch_if.chan bus
);
    logic [7:0] ie_q, ie_d, rxset_q, rxset_d, mode_q, mode_d, txctl_q, txctl_d;
    logic [7:0] brg_lo_q, brg_lo_d, brg_hi_q, brg_hi_d;
    logic [2:0] ip_q, ip_d, ius_q, ius_d, eoi_clr;
    logic brg_en_q, brg_en_d, txd_q, txd_d, rts_n_q, rts_n_d, dtr_n_q, dtr_n_d;

    always_comb begin
        eoi_clr = 3'h0;
        ie_d = ie_q;
        rxset_d = rxset_q;
        mode_d = mode_q;
        txctl_d = txctl_q;
        brg_lo_d = brg_lo_q;
        brg_hi_d = brg_hi_q;
        brg_en_d = brg_en_q;
        if (bus.eoi) begin
            if (ius_q[SRC_RX]) begin
                eoi_clr[SRC_RX] = 1'b1;
            end else if (ius_q[SRC_TX]) begin
                eoi_clr[SRC_TX] = 1'b1;
            end else begin
                eoi_clr[SRC_EXT] = ius_q[SRC_EXT];
            end
        end
        if (bus.wr) begin
            unique case (bus.idx)
                REG_IE: ie_d = bus.wdata;
                REG_RXSET: rxset_d = bus.wdata;
                REG_MODE: mode_d = bus.wdata;
                REG_TXCTL: txctl_d = bus.wdata;
                REG_BRG_LO: brg_lo_d = bus.wdata;
                REG_BRG_HI: brg_hi_d = bus.wdata;
                REG_BRG_EN: brg_en_d = bus.wdata[BRG_EN_BIT];
                default: ;
            endcase
        end
        // an event in the clearing cycle still lands
        ius_d = (ius_q & ~eoi_clr) | bus.ack;
        ip_d = (ip_q & ~bus.ack) | (bus.ev & ie_q[2:0]);
        txd_d = txctl_q[TX_EN_BIT] ? bus.txd_src : 1'b1;
        if (bus.chan_rst) begin
            rxset_d[RX_EN_BIT] = 1'b0;
            txctl_d[TX_EN_BIT] = 1'b0;
            txctl_d[RTS_BIT] = 1'b0;
            txctl_d[DTR_BIT] = 1'b0;
            ie_d = REG8_RST;
            ip_d = 3'h0;
            ius_d = 3'h0;
            txd_d = 1'b1;
        end
        // modem pins are active low, so inactive means high
        rts_n_d = ~txctl_d[RTS_BIT];
        dtr_n_d = ~txctl_d[DTR_BIT];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ie_q <= REG8_RST;
            rxset_q <= REG8_RST;
            mode_q <= REG8_RST;
            txctl_q <= REG8_RST;
            brg_lo_q <= REG8_RST;
            brg_hi_q <= REG8_RST;
            brg_en_q <= 1'b0;
            ip_q <= 3'h0;
            ius_q <= 3'h0;
            txd_q <= 1'b1;
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
        end else begin
            ie_q <= ie_d;
            rxset_q <= rxset_d;
            mode_q <= mode_d;
            txctl_q <= txctl_d;
            brg_lo_q <= brg_lo_d;
            brg_hi_q <= brg_hi_d;
            brg_en_q <= brg_en_d;
            ip_q <= ip_d;
            ius_q <= ius_d;
            txd_q <= txd_d;
            rts_n_q <= rts_n_d;
            dtr_n_q <= dtr_n_d;
        end
    end

    assign bus.ie = ie_q;
    assign bus.rxset = rxset_q;
    assign bus.mode = mode_q;
    assign bus.txctl = txctl_q;
    assign bus.brg_lo = brg_lo_q;
    assign bus.brg_hi = brg_hi_q;
    assign bus.brg_en = brg_en_q;
    assign bus.ip = ip_q;
    assign bus.interrupt_under_service_flag = ius_q;
    assign bus.txd = txd_q;
    assign bus.rts_n = rts_n_q;
    assign bus.dtr_n = dtr_n_q;

    chk_ip_set_wins: assert property (@(posedge mclk) disable iff (rst)
        (bus.ev[SRC_RX] && ie_q[SRC_RX] && !bus.chan_rst) |=> ip_q[SRC_RX])
        else $error("pending rx event was lost");
endmodule

// ===== hdl/sci_top.sv
module sci_top import sci_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // interrupt acknowledge and vector pins
    input wire logic iack,
    output logic [7:0] vec_out,
    output logic vec_oe_n,
    output logic int_n,
    output logic ieo,
    // channel a pins
    input wire logic [2:0] ev_a,
    input wire logic txd_src_a,
    output logic txd_a,
    output logic rts_n_a,
    output logic dtr_n_a,
    output logic rx_en_a,
    output logic tx_en_a,
    output logic brg_en_a,
    // channel b pins
    input wire logic [2:0] ev_b,
    input wire logic txd_src_b,
    output logic txd_b,
    output logic rts_n_b,
    output logic dtr_n_b,
    output logic rx_en_b,
    output logic tx_en_b,
    output logic brg_en_b
);
    sci_ch_if ca ();
    sci_ch_if cb ();

    logic [4:0] mic_q, mic_d;
    logic [7:0] vec_q, vec_d, rdata_q, rdata_d, vout_q, vout_d, rd_mux;
    logic oe_n_q, oe_n_d, int_n_q, int_n_d, ieo_q, ieo_d;
    sci_iack_t ia_q, ia_d;
    logic [3:0] idx;
    logic is_b, mic_wr, take, pend;
    logic [1:0] cmd;
    logic [2:0] sel_code;
    logic [2:0] sel_a, sel_b;

    function automatic logic [7:0] mod_vec(input logic [7:0] v, input logic [2:0] c,
                                           input logic hi);
        mod_vec = hi ? {v[7], c[0], c[1], c[2], v[3:0]} : {v[7:4], c, v[0]};
    endfunction

    assign idx = addr[3:0];
    assign is_b = addr[CHB_BIT];
    assign mic_wr = wr_stb && (idx == REG_MIC);
    assign cmd = wdata[MIC_CMD_LO+1:MIC_CMD_LO];

    // channel decode; master and vector registers are shared
    assign ca.wr = wr_stb && !is_b;
    assign cb.wr = wr_stb && is_b;
    assign ca.idx = idx;
    assign cb.idx = idx;
    assign ca.wdata = wdata;
    assign cb.wdata = wdata;
    assign ca.chan_rst = mic_wr && (cmd == CMD_RST_A || cmd == CMD_RST_HW);
    assign cb.chan_rst = mic_wr && (cmd == CMD_RST_B || cmd == CMD_RST_HW);
    assign ca.eoi = ca.wr && (idx == REG_STATUS) && wdata[EOI_BIT];
    assign cb.eoi = cb.wr && (idx == REG_STATUS) && wdata[EOI_BIT];
    assign ca.ev = ev_a;
    assign cb.ev = ev_b;
    assign ca.txd_src = txd_src_a;
    assign cb.txd_src = txd_src_b;
    assign ca.ack = take ? sel_a : 3'h0;
    assign cb.ack = take ? sel_b : 3'h0;

    sci_chan u_cha (
        .mclk(mclk),
        .rst(rst),
        .bus(ca.chan)
    );

    sci_chan u_chb (
        .mclk(mclk),
        .rst(rst),
        .bus(cb.chan)
    );

    // fixed priority: a before b, rx before tx before external
    always_comb begin
        sel_code = VC_NONE;
        sel_a = 3'h0;
        sel_b = 3'h0;
        if (ca.ip[SRC_RX]) begin
            sel_code = VC_A_RX;
            sel_a[SRC_RX] = 1'b1;
        end else if (ca.ip[SRC_TX]) begin
            sel_code = VC_A_TX;
            sel_a[SRC_TX] = 1'b1;
        end else if (ca.ip[SRC_EXT]) begin
            sel_code = VC_A_EXT;
            sel_a[SRC_EXT] = 1'b1;
        end else if (cb.ip[SRC_RX]) begin
            sel_code = VC_B_RX;
            sel_b[SRC_RX] = 1'b1;
        end else if (cb.ip[SRC_TX]) begin
            sel_code = VC_B_TX;
            sel_b[SRC_TX] = 1'b1;
        end else if (cb.ip[SRC_EXT]) begin
            sel_code = VC_B_EXT;
            sel_b[SRC_EXT] = 1'b1;
        end
    end

    assign pend = |{ca.ip, cb.ip};
    assign take = iack && (ia_q == IA_IDLE) && mic_q[MIC_MIE] && pend;

    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            REG_STATUS: begin
                rd_mux = is_b ? {cb.rxset[RX_EN_BIT], cb.txctl[TX_EN_BIT], cb.interrupt_under_service_flag, cb.ip}
                              : {ca.rxset[RX_EN_BIT], ca.txctl[TX_EN_BIT], ca.interrupt_under_service_flag, ca.ip};
            end
            REG_IPEND: rd_mux = is_b ? 8'h00 : {2'h0, ca.ip, cb.ip};
            REG_VEC: rd_mux = is_b ? mod_vec(vec_q, sel_code, mic_q[MIC_STHI]) : vec_q;
            REG_BRG_LO: rd_mux = is_b ? cb.brg_lo : ca.brg_lo;
            REG_BRG_HI: rd_mux = is_b ? cb.brg_hi : ca.brg_hi;
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        mic_d = mic_q;
        vec_d = vec_q;
        if (mic_wr) begin
            // every write replaces all mode bits, commands included or not
            mic_d = wdata[MIC_MODE_W-1:0];
        end
        if (wr_stb && (idx == REG_VEC)) begin
            vec_d = wdata;
        end
        rdata_d = rd_stb ? rd_mux : 8'h00;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mic_q <= MIC_RST;
            vec_q <= REG8_RST;
            rdata_q <= 8'h00;
        end else begin
            mic_q <= mic_d;
            vec_q <= vec_d;
            rdata_q <= rdata_d;
        end
    end

    // acknowledge: one cycle of vector drive after the acknowledge pulse
    always_comb begin
        ia_d = IA_IDLE;
        oe_n_d = 1'b1;
        vout_d = 8'h00;
        if (take) begin
            ia_d = IA_DRIVE;
            oe_n_d = mic_q[MIC_NV];
            vout_d = mic_q[MIC_VIS] ? mod_vec(vec_q, sel_code, mic_q[MIC_STHI]) : vec_q;
        end
        int_n_d = !(mic_q[MIC_MIE] && pend);
        // lower chain held off while anything is under service here
        ieo_d = !mic_q[MIC_DLC] && !(|{ca.interrupt_under_service_flag, cb.interrupt_under_service_flag});
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ia_q <= IA_IDLE;
            oe_n_q <= 1'b1;
            vout_q <= 8'h00;
            int_n_q <= 1'b1;
            ieo_q <= 1'b1;
        end else begin
            ia_q <= ia_d;
            oe_n_q <= oe_n_d;
            vout_q <= vout_d;
            int_n_q <= int_n_d;
            ieo_q <= ieo_d;
        end
    end

    assign rdata = rdata_q;
    assign vec_out = vout_q;
    assign vec_oe_n = oe_n_q;
    assign int_n = int_n_q;
    assign ieo = ieo_q;
    assign txd_a = ca.txd;
    assign rts_n_a = ca.rts_n;
    assign dtr_n_a = ca.dtr_n;
    assign rx_en_a = ca.rxset[RX_EN_BIT];
    assign tx_en_a = ca.txctl[TX_EN_BIT];
    assign brg_en_a = ca.brg_en;
    assign txd_b = cb.txd;
    assign rts_n_b = cb.rts_n;
    assign dtr_n_b = cb.dtr_n;
    assign rx_en_b = cb.rxset[RX_EN_BIT];
    assign tx_en_b = cb.txctl[TX_EN_BIT];
    assign brg_en_b = cb.brg_en;

    default clocking cb_main @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_reset_chan_a: assert property (
        (mic_wr && cmd[1]) |=> (!rx_en_a && !tx_en_a && ca.ip == 3'h0 && ca.interrupt_under_service_flag == 3'h0
            && txd_a && rts_n_a && dtr_n_a && ca.ie == 8'h00))
        else $error("channel a reset incomplete");
    chk_reset_chan_b: assert property (
        (mic_wr && cmd[0]) |=> (!rx_en_b && !tx_en_b && cb.ip == 3'h0 && cb.interrupt_under_service_flag == 3'h0
            && txd_b && rts_n_b && dtr_n_b && cb.ie == 8'h00))
        else $error("channel b reset incomplete");
    chk_cmd_spares_a: assert property (
        (mic_wr && cmd == CMD_RST_B) |=> (rx_en_a == $past(rx_en_a) && tx_en_a == $past(tx_en_a)))
        else $error("channel b reset touched channel a");
    chk_chan_isolated: assert property (
        (wr_stb && is_b && idx != REG_MIC) |=> $stable(ca.rxset) && $stable(ca.txctl))
        else $error("channel b write altered channel a");
    chk_mode_taken: assert property (
        mic_wr |=> mic_q == $past(wdata[MIC_MODE_W-1:0]))
        else $error("mode bits not stored");
    chk_mode_held: assert property (
        !mic_wr |=> $stable(mic_q))
        else $error("mode bits changed without a write");
    chk_novec_quiet: assert property (
        (iack && mic_q[MIC_NV]) |=> vec_oe_n ##1 vec_oe_n)
        else $error("vector driven in no-vector mode");
    chk_vec_one_cycle: assert property (
        (take && !mic_q[MIC_NV]) |=> !vec_oe_n ##1 vec_oe_n)
        else $error("vector drive not exactly one cycle");
    chk_read_data: assert property (
        (rd_stb && !is_b && idx == REG_BRG_LO) |=> rdata == ca.brg_lo)
        else $error("read data wrong");

    // channel b mirrors of the isolation and command scope checks, then command, pin, interrupt, chain, vector and read checks
    chk_isolated_b: assert property (
        (wr_stb && !is_b && idx != REG_MIC) |=> $stable({cb.rxset, cb.txctl, cb.ie}))
        else $error("channel a write altered channel b");
    chk_cmd_spares_b: assert property (
        (mic_wr && cmd == CMD_RST_A) |=> $stable({rx_en_b, tx_en_b}))
        else $error("channel a reset touched channel b");
    chk_cmd_none_keeps: assert property (
        (mic_wr && cmd == CMD_NONE) |=> $stable({rx_en_a, rx_en_b, tx_en_a, tx_en_b}))
        else $error("mode-only write reset a channel");
    chk_txd_mark_a: assert property (
        !tx_en_a |=> txd_a)
        else $error("channel a line not marking while tx off");
    chk_txd_mark_b: assert property (
        !tx_en_b |=> txd_b)
        else $error("channel b line not marking while tx off");
    chk_reset_ints_off: assert property (
        (mic_wr && cmd == CMD_RST_HW) |=> ##1 int_n)
        else $error("interrupt request survived full reset");
    chk_modem_high_hw: assert property (
        (mic_wr && cmd == CMD_RST_HW) |=> (rts_n_a && rts_n_b && dtr_n_a && dtr_n_b))
        else $error("modem pins not high after full reset");
    chk_mie_gate: assert property (
        !mic_q[MIC_MIE] |=> int_n)
        else $error("interrupt request with master enable off");
    chk_int_raised: assert property (
        (mic_q[MIC_MIE] && pend) |=> !int_n)
        else $error("pending interrupt not requested");
    chk_ack_needs_mie: assert property (
        (iack && !mic_q[MIC_MIE]) |=> vec_oe_n)
        else $error("acknowledge taken with master enable off");
    chk_chain_off: assert property (
        mic_q[MIC_DLC] |=> !ieo)
        else $error("lower chain enabled while disabled by mode");
    chk_vec_supplied: assert property (
        (take && !mic_q[MIC_VIS]) |=> vec_out == $past(vec_q))
        else $error("stored vector not supplied");
    chk_ack_serviced: assert property (
        take |=> (ca.interrupt_under_service_flag != 3'h0 || cb.interrupt_under_service_flag != 3'h0))
        else $error("acknowledge left nothing under service");
    chk_ack_refused: assert property (
        (iack && !pend) |=> vec_oe_n)
        else $error("vector driven with nothing pending");
    chk_rdata_idle: assert property (
        !rd_stb |=> rdata == 8'h00)
        else $error("read data outside read slot");
    chk_mic_unreadable: assert property (
        (rd_stb && idx == REG_MIC) |=> rdata == 8'h00)
        else $error("master control read back");

    cov_hw_reset: cover property (mic_wr && cmd == CMD_RST_HW);
    cov_vec_drive: cover property (take && !mic_q[MIC_NV] ##1 !vec_oe_n);
    cov_novec_ack: cover property (take && mic_q[MIC_NV]);
    cov_rx_enable: cover property (!rx_en_a ##1 rx_en_a);
    cov_chain_off: cover property (mic_q[MIC_DLC] ##1 !ieo);
endmodule

// ===== sim/serial_ctrl_init_and_reset_tb.sv
module serial_ctrl_init_and_reset_tb import sci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rst;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rdata;
    logic iack;
    logic [7:0] vec_out;
    logic vec_oe_n;
    logic int_n;
    logic ieo;
    logic [2:0] ev_a;
    logic [2:0] ev_b;
    logic txd_src_a;
    logic txd_src_b;
    logic txd_a, rts_n_a, dtr_n_a, rx_en_a, tx_en_a, brg_en_a;
    logic txd_b, rts_n_b, dtr_n_b, rx_en_b, tx_en_b, brg_en_b;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    sci_top dut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .iack(iack), .vec_out(vec_out),
        .vec_oe_n(vec_oe_n), .int_n(int_n), .ieo(ieo),
        .ev_a(ev_a), .txd_src_a(txd_src_a), .txd_a(txd_a), .rts_n_a(rts_n_a),
        .dtr_n_a(dtr_n_a), .rx_en_a(rx_en_a), .tx_en_a(tx_en_a), .brg_en_a(brg_en_a),
        .ev_b(ev_b), .txd_src_b(txd_src_b), .txd_b(txd_b), .rts_n_b(rts_n_b),
        .dtr_n_b(dtr_n_b), .rx_en_b(rx_en_b), .tx_en_b(tx_en_b), .brg_en_b(brg_en_b)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask

    // read data lives only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic pulse_ev(input logic [2:0] a, input logic [2:0] b);
        @(posedge mclk);
        ev_a <= a;
        ev_b <= b;
        @(posedge mclk);
        ev_a <= 3'h0;
        ev_b <= 3'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic ack_cycle(input logic [7:0] exp_oe_n, input logic [7:0] exp_vec);
        @(posedge mclk);
        iack <= 1'b1;
        @(posedge mclk);
        iack <= 1'b0;
        #1;
        check({7'h0, vec_oe_n}, exp_oe_n);
        if (exp_oe_n == 8'h00) begin
            check(vec_out, exp_vec);
        end
        @(posedge mclk);
        #1;
        check({7'h0, vec_oe_n}, 8'h01);
    endtask

    // {tx_en, rx_en, rts_n, dtr_n, txd, brg_en}
    function automatic logic [7:0] pins(input int ch);
        if (ch == 0) begin
            return {2'h0, tx_en_a, rx_en_a, rts_n_a, dtr_n_a, txd_a, brg_en_a};
        end
        return {2'h0, tx_en_b, rx_en_b, rts_n_b, dtr_n_b, txd_b, brg_en_b};
    endfunction

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        addr = 5'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        iack = 1'b0;
        ev_a = 3'h0;
        ev_b = 3'h0;
        txd_src_a = 1'b0;
        txd_src_b = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        #1;
        check(pins(0), 8'h0e);
        check(pins(1), 8'h0e);
        // every reset command, each channel enabled beforehand
        for (int c = 1; c < 4; c++) begin
            for (int ch = 0; ch < 2; ch++) begin
                wr({ch[0], REG_MODE}, 8'h44);
                wr({ch[0], REG_RXSET}, 8'h02);
                wr({ch[0], REG_TXCTL}, 8'h8a);
                wr({ch[0], REG_RXSET}, 8'h03);
                wr({ch[0], REG_BRG_EN}, 8'h01);
            end
            repeat (2) @(posedge mclk);
            #1;
            check(pins(0), 8'h31);
            check(pins(1), 8'h31);
            wr({1'b0, REG_MIC}, {c[1:0], 6'h00});
            repeat (2) @(posedge mclk);
            #1;
            check(pins(0), c[1] ? 8'h0f : 8'h31);
            check(pins(1), c[0] ? 8'h0f : 8'h31);
        end
        // per-channel constants stay apart
        wr({1'b0, REG_BRG_LO}, 8'h5a);
        wr({1'b1, REG_BRG_LO}, 8'ha5);
        rd({1'b0, REG_BRG_LO}, 8'h5a);
        rd({1'b1, REG_BRG_LO}, 8'ha5);
        wr({1'b1, REG_BRG_HI}, 8'h3c);
        rd({1'b1, REG_BRG_HI}, 8'h3c);
        rd({1'b0, REG_BRG_HI}, 8'h00);
        rd({1'b1, REG_IPEND}, 8'h00);
        rd({1'b0, 4'h7}, 8'h00);
        rd({1'b0, REG_MIC}, 8'h00);
        // pending interrupt gated by the master enable mode bit
        wr({1'b0, REG_IE}, 8'h04);
        wr({1'b0, REG_VEC}, 8'h50);
        wr({1'b0, REG_MIC}, 8'h00);
        pulse_ev(3'h4, 3'h4);
        rd({1'b0, REG_STATUS}, 8'h04);
        rd({1'b0, REG_IPEND}, 8'h20);
        check({7'h0, int_n}, 8'h01);
        wr({1'b0, REG_MIC}, 8'h08);
        repeat (2) @(posedge mclk);
        #1;
        check({7'h0, int_n}, 8'h00);
        ack_cycle(8'h00, 8'h50);
        rd({1'b0, REG_STATUS}, 8'h20);
        wr({1'b0, REG_STATUS}, 8'h20);
        rd({1'b0, REG_STATUS}, 8'h00);
        // no-vector mode: acknowledge taken but bus left alone
        pulse_ev(3'h4, 3'h0);
        wr({1'b0, REG_MIC}, 8'h0a);
        ack_cycle(8'h01, 8'h00);
        // channel a reset with mode bits re-supplied
        pulse_ev(3'h4, 3'h0);
        wr({1'b0, REG_MIC}, 8'h8a);
        repeat (2) @(posedge mclk);
        #1;
        rd({1'b0, REG_STATUS}, 8'h00);
        check({7'h0, int_n}, 8'h01);
        pulse_ev(3'h4, 3'h0);
        rd({1'b0, REG_STATUS}, 8'h00);
        wr({1'b0, REG_IE}, 8'h04);
        pulse_ev(3'h4, 3'h0);
        check({7'h0, int_n}, 8'h00);
        ack_cycle(8'h01, 8'h00);
        // mode bits: lower chain and status position in one write, then vector status
        wr({1'b0, REG_STATUS}, 8'h20);
        wr({1'b0, REG_MIC}, 8'h00);
        repeat (2) @(posedge mclk);
        #1;
        check({7'h0, ieo}, 8'h01);
        rd({1'b1, REG_VEC}, 8'h56);
        wr({1'b0, REG_MIC}, 8'h14);
        rd({1'b1, REG_VEC}, 8'h60);
        check({7'h0, ieo}, 8'h00);
        pulse_ev(3'h4, 3'h0);
        wr({1'b0, REG_MIC}, 8'h09);
        ack_cycle(8'h00, 8'h5c);
        conclude();
    end
endmodule
